// [hw/mci_pkg.sv]
// constants and types of the midi control interpreter
// Notes on behaviour
// R1: fine playback pitch in cents, -100..+100
// R2: coarse playback pitch spans two octaves each way
// R3: reference key C1..C6 lets notes set pitch
// R4: note-off stops sample playback
// R5: pass-through mode echoes input to output
// R6: transmit mode sends bulk dumps on output
// R7: program change recalls memory via bank table
// R8: entry is preset, user, card or none
// R9: controller source: cc, key, velocity, pressure
// R10: note-on opens gate for triggered effect types
// R11: note-on sets pitch interval for pitch programs
// R12: harmony with external trigger uses note interval
// R13: timing clock sets tempo for tempo echoes
// R14: dump request on matching channel starts dump
// R15: sysex bank change switches active bank
// R16: bulk data needs protect off, matching channel
// R17: bulk data overwrites addressed table entries
// R18: sender uses selected bank's receive channel
// R19: indicator lit while input data arrives
// R20: one cc number per controller, all programs
// R21: controller value scaled into min/max window
// R22: other channels' voice messages are ignored
// R23: unassigned program change leaves program unchanged
package mci_pkg;
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned MIDI_BAUD = 31_250;
  localparam int unsigned BIT_CYC   = CLK_HZ / MIDI_BAUD;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CHAN   = 8'h04;
  localparam logic [7:0] OFS_CTLASN = 8'h08;
  localparam logic [7:0] OFS_RANGE  = 8'h0c;
  localparam logic [7:0] OFS_PITCH  = 8'h10;
  localparam logic [7:0] OFS_TABLE  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PARAM  = 8'h1c;
  localparam logic [7:0] OFS_TEMPO  = 8'h20;

  // control word fields
  localparam int unsigned CTRL_XMIT    = 0;
  localparam int unsigned CTRL_PROTECT = 1;
  localparam int unsigned CTRL_BANK    = 2;
  localparam int unsigned CTRL_TRIGF   = 4;
  localparam int unsigned CTRL_HARMONY = 5;
  localparam int unsigned CTRL_TRIGEXT = 6;
  localparam int unsigned CTRL_EFF     = 8;
  localparam int unsigned CTRL_DUMPGO  = 12;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [19:0] CHAN_RST   = 20'h00000;
  localparam logic [31:0] CTLASN_RST = 32'h0000_0201;
  localparam logic [31:0] RANGE_RST  = 32'h6400_6400;

  // effect type codes
  localparam logic [3:0] EFF_OTHER   = 4'h0;
  localparam logic [3:0] EFF_REVERB  = 4'h1;
  localparam logic [3:0] EFF_FILTERED_REVERB_PROGRAM = 4'h2;
  localparam logic [3:0] EFF_ECHO_ROOM_PROGRAM = 4'h3;
  localparam logic [3:0] EFF_TRIGGERED_PAN_PROGRAM = 4'h4;
  localparam logic [3:0] EFF_MONO_PITCH_PROGRAM = 4'h5;
  localparam logic [3:0] EFF_DUAL_PITCH_PROGRAM = 4'h6;
  localparam logic [3:0] EFF_TRIPLE_PITCH_PROGRAM = 4'h7;
  localparam logic [3:0] EFF_STEREO_PITCH_PROGRAM   = 4'h8;
  localparam logic [3:0] EFF_FREEZE  = 4'h9;
  localparam logic [3:0] EFF_TEMPO_ECHO_SINGLE = 4'ha;
  localparam logic [3:0] EFF_TEMPO_ECHO_DOUBLE = 4'hb;
  localparam logic [3:0] EFF_TEMPO_ECHO_QUAD = 4'hc;

  localparam logic [6:0] KEY_C1    = 7'h24;
  localparam logic [6:0] KEY_C6    = 7'h60;
  localparam logic [7:0] PITCH_LIM = 8'h18;
  localparam logic [7:0] FINE_LIM  = 8'h64;
  localparam logic [8:0] CODE_MAX  = 9'h118;

  localparam logic [7:0] ST_SYSEX = 8'hf0;
  localparam logic [7:0] ST_EOX   = 8'hf7;
  localparam logic [7:0] ST_CLOCK = 8'hf8;
  localparam logic [2:0] SX_BULK  = 3'h0;
  localparam logic [2:0] SX_BANKC = 3'h1;
  localparam logic [2:0] SX_REQ   = 3'h2;
  localparam logic [8:0] DUMP_LAST = 9'h104;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {SX_IDLE, SX_ID, SX_CMD, SX_BANK, SX_DATA, SX_SKIP} mci_sx_t;
endpackage

// [hw/mci_uart_rx.sv]
// serial byte receiver for the midi input line
`timescale 1ns/100ps
module mci_uart_rx #(
  parameter int unsigned BIT_CYC = mci_pkg::BIT_CYC
) (
  input  logic       aclk,
  input  logic       aresetn,
  input  logic       rxd,
  output logic       busy,
  output logic       valid,
  output logic [7:0] data
);
  localparam int unsigned CW = $clog2(BIT_CYC);
  logic [CW-1:0] cnt_q;
  logic [3:0]    bit_q;
  logic [7:0]    sh_q;
  logic          tick;

  // one-cycle enable at each bit centre
  assign tick = (cnt_q == CW'(BIT_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      busy  <= 1'b0;
      valid <= 1'b0;
      data  <= 8'h00;
    end else begin
      valid <= 1'b0;
      if (!busy) begin
        if (!rxd) begin
          busy  <= 1'b1;
          cnt_q <= CW'(BIT_CYC / 2);
          bit_q <= 4'h0;
        end
      end else if (tick) begin
        cnt_q <= '0;
        bit_q <= bit_q + 4'h1;
        // a glitch shorter than half a bit is not a start bit
        if (bit_q == 4'h0 && rxd) begin
          busy <= 1'b0;
        end else if (bit_q >= 4'h1 && bit_q <= 4'h8) begin
          sh_q <= {rxd, sh_q[7:1]};
        end else if (bit_q == 4'h9) begin
          busy <= 1'b0;
          if (rxd) begin
            valid <= 1'b1;
            data  <= sh_q;
          end
        end
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end
endmodule

// [hw/mci_top.sv]
// midi control interpreter with axi4-lite register access
`timescale 1ns/100ps
module mci_top #(
  parameter int unsigned BIT_CYC = mci_pkg::BIT_CYC,
  parameter logic [6:0]  MFR_ID  = 7'h7d
) (
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [7:0]  s_awaddr,
  input  logic        s_awvalid,
  output logic        s_awready,
  input  logic [31:0] s_wdata,
  input  logic [3:0]  s_wstrb,
  input  logic        s_wvalid,
  output logic        s_wready,
  output logic [1:0]  s_bresp,
  output logic        s_bvalid,
  input  logic        s_bready,
  input  logic [7:0]  s_araddr,
  input  logic        s_arvalid,
  output logic        s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0]  s_rresp,
  output logic        s_rvalid,
  input  logic        s_rready,
  input  logic        midi_in,
  output logic        midi_out,
  output logic        midi_led,
  output logic        recall_valid,
  output logic [8:0]  recall_code,
  output logic [7:0]  param1_val,
  output logic [7:0]  param2_val,
  output logic        gate_open,
  output logic        playing,
  output logic [7:0]  pitch_semi,
  output logic [7:0]  pitch_fine,
  output logic [7:0]  harmony_interval,
  output logic [23:0] tempo_cycles
);
  // MFR_ID is an arbitrary sysex identity value
  logic [7:0]  awaddr_q, araddr_q;
  logic [31:0] wdata_q, ctrl_q, ctlasn_q, range_q, wr_val;
  logic [3:0]  wstrb_q;
  logic        have_aw_q, have_w_q, wr_en;
  logic [1:0]  bank_q;
  logic [19:0] chan_q;
  logic [6:0]  ref_q;
  logic [8:0]  tbl_ix_q;
  logic [8:0]  tbl [512];
  logic [7:0]  par_q [2];
  logic        rx_busy, rx_v;
  logic [7:0]  rx_b;
  logic [7:0]  run_q, d1_q, msg_st_q, msg_d1_q, msg_d2_q, hi_q;
  logic        have_d1_q, msg_v_q, sx_bank_mode_q, sx_hi_ph_q;
  mci_pkg::mci_sx_t sx_q;
  logic [1:0]  blk_bank_q;
  logic [6:0]  blk_ix_q;
  logic [23:0] clk_cnt_q;
  logic        dump_act_q, dump_req_q, tx_busy_q, tx_line;
  logic [8:0]  dump_ix_q, dump_tmp, dump_ent;
  logic [9:0]  tx_sh_q;
  logic [3:0]  tx_bit_q;
  logic [15:0] tx_cnt_q;
  logic [7:0]  dump_byte;
  logic [4:0]  cur_ch;
  logic [3:0]  eff;
  logic        ch_on, msg_ok, note_on, note_off, key_on;
  logic [7:0]  note_int;

  mci_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rxd     (midi_in),
    .busy    (rx_busy),
    .valid   (rx_v),
    .data    (rx_b)
  );

  function automatic logic [7:0] clamp_s(input logic signed [8:0] v, input logic [7:0] lim);
    logic signed [8:0] l9;
    l9 = $signed({1'b0, lim});
    if (v > l9) return lim;
    if (v < -l9) return 8'(-l9);
    return v[7:0];
  endfunction

  function automatic logic [7:0] scale(input logic [6:0] mn, input logic [6:0] mx,
                                       input logic [6:0] v);
    logic [13:0] p;
    if (mx >= mn) begin
      p = 14'((mx - mn) * v);
      return {1'b0, mn} + 8'(p / 14'd127);
    end
    p = 14'((mn - mx) * v);
    return {1'b0, mn} - 8'(p / 14'd127);
  endfunction

  assign eff    = ctrl_q[mci_pkg::CTRL_EFF +: 4];
  assign cur_ch = chan_q[5*bank_q +: 5];
  assign ch_on  = !cur_ch[4];
  assign key_on = (ref_q != 7'h00);
  assign msg_ok = msg_v_q && ch_on && (msg_st_q[3:0] == cur_ch[3:0]); // see R22
  assign note_on  = msg_ok && msg_st_q[7:4] == 4'h9 && msg_d2_q != 8'h00;
  assign note_off = msg_ok && (msg_st_q[7:4] == 4'h8 ||
                    (msg_st_q[7:4] == 4'h9 && msg_d2_q == 8'h00));
  assign note_int = clamp_s(9'($signed({2'b00, msg_d1_q[6:0]}) - $signed({2'b00, ref_q})),
                            mci_pkg::PITCH_LIM); // see R3

  function automatic logic [31:0] reg_view(input logic [7:0] a);
    case (a)
      mci_pkg::OFS_CTRL:   reg_view = {ctrl_q[31:4], bank_q, ctrl_q[1:0]};
      mci_pkg::OFS_CHAN:   reg_view = {12'h000, chan_q};
      mci_pkg::OFS_CTLASN: reg_view = ctlasn_q;
      mci_pkg::OFS_RANGE:  reg_view = range_q;
      mci_pkg::OFS_PITCH:  reg_view = {9'h000, ref_q, pitch_fine, pitch_semi};
      mci_pkg::OFS_TABLE:  reg_view = {14'h0000, tbl_ix_q, tbl[tbl_ix_q]};
      mci_pkg::OFS_STATUS: reg_view = {20'h00000, dump_act_q, gate_open, playing,
                                       recall_code};
      mci_pkg::OFS_PARAM:  reg_view = {16'h0000, par_q[1], par_q[0]};
      mci_pkg::OFS_TEMPO:  reg_view = {8'h00, tempo_cycles};
      default:             reg_view = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= mci_pkg::OFS_TEMPO;
  endfunction

  always_comb begin
    wr_val = reg_view(awaddr_q);
    for (int i = 0; i < 4; i++) begin
      if (wstrb_q[i]) wr_val[8*i +: 8] = wdata_q[8*i +: 8];
    end
  end
  assign wr_en = have_aw_q && have_w_q && !s_bvalid;

  // axi write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= mci_pkg::RESP_OKAY;
      have_aw_q <= 1'b0;
      have_w_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        awaddr_q  <= s_awaddr;
        have_aw_q <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wdata_q  <= s_wdata;
        wstrb_q  <= s_wstrb;
        have_w_q <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_en) begin
        s_bvalid <= 1'b1;
        s_bresp  <= mapped(awaddr_q) ? mci_pkg::RESP_OKAY : mci_pkg::RESP_SLVERR;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        have_aw_q <= 1'b0;
        have_w_q  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // axi read channel: data one edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= mci_pkg::RESP_OKAY;
      araddr_q  <= 8'h00;
    end else if (s_arvalid && s_arready) begin
      araddr_q  <= s_araddr;
      s_rdata   <= reg_view(s_araddr);
      s_rresp   <= mapped(s_araddr) ? mci_pkg::RESP_OKAY : mci_pkg::RESP_SLVERR;
      s_rvalid  <= 1'b1;
      s_arready <= 1'b0;
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= mci_pkg::CTRL_RST;
      chan_q   <= mci_pkg::CHAN_RST;
      ctlasn_q <= mci_pkg::CTLASN_RST;
      range_q  <= mci_pkg::RANGE_RST;
      ref_q    <= 7'h00;
      tbl_ix_q <= 9'h000;
    end else if (wr_en) begin
      case (awaddr_q)
        mci_pkg::OFS_CTRL:   ctrl_q <= {19'h00000, 1'b0, wr_val[11:0]};
        mci_pkg::OFS_CHAN:   chan_q <= wr_val[19:0];
        mci_pkg::OFS_CTLASN: ctlasn_q <= wr_val; // see R20
        mci_pkg::OFS_RANGE:  range_q <= wr_val;
        mci_pkg::OFS_TABLE:  tbl_ix_q <= wr_val[17:9];
        mci_pkg::OFS_PITCH: begin
          // only C1..C6 selects a key, anything else turns note pitch off
          if (wr_val[22:16] >= mci_pkg::KEY_C1 && wr_val[22:16] <= mci_pkg::KEY_C6)
            ref_q <= wr_val[22:16]; // see R3
          else
            ref_q <= 7'h00;
        end
        default: ;
      endcase
    end
  end

  // active bank: software write or sysex bank change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_q <= 2'h0;
    end else if (msg_v_q && sx_bank_mode_q && msg_st_q == mci_pkg::ST_SYSEX) begin
      bank_q <= msg_d1_q[1:0]; // see R15
    end else if (wr_en && awaddr_q == mci_pkg::OFS_CTRL) begin
      bank_q <= wr_val[mci_pkg::CTRL_BANK +: 2];
    end
  end

  // program table; incoming bulk data wins a same-cycle clash with software
  always_ff @(posedge aclk) begin
    if (sx_q == mci_pkg::SX_DATA && rx_v && !rx_b[7] && !sx_hi_ph_q) begin
      tbl[{blk_bank_q, blk_ix_q}] <= ({hi_q[1:0], rx_b[6:0]} > mci_pkg::CODE_MAX) ? 9'h000 :
                                     {hi_q[1:0], rx_b[6:0]}; // see R8 R17
    end else if (wr_en && awaddr_q == mci_pkg::OFS_TABLE) begin
      tbl[wr_val[17:9]] <= (wr_val[8:0] > mci_pkg::CODE_MAX) ? 9'h000 : wr_val[8:0]; // see R8
    end
  end

  // byte parser with running status; sysex handled in place
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 8'h00;
      d1_q <= 8'h00;
      have_d1_q <= 1'b0;
      msg_v_q <= 1'b0;
      msg_st_q <= 8'h00;
      msg_d1_q <= 8'h00;
      msg_d2_q <= 8'h00;
      sx_q <= mci_pkg::SX_IDLE;
      sx_bank_mode_q <= 1'b0;
      sx_hi_ph_q <= 1'b1;
      hi_q <= 8'h00;
      blk_bank_q <= 2'h0;
      blk_ix_q <= 7'h00;
      dump_req_q <= 1'b0;
    end else begin
      msg_v_q <= 1'b0;
      dump_req_q <= 1'b0;
      if (rx_v && rx_b == mci_pkg::ST_CLOCK) begin
        msg_v_q  <= 1'b1; // realtime byte, does not break other messages
        msg_st_q <= rx_b;
      end else if (rx_v && rx_b[7]) begin
        have_d1_q <= 1'b0;
        run_q <= (rx_b[7:4] == 4'hf) ? 8'h00 : rx_b;
        sx_q <= (rx_b == mci_pkg::ST_SYSEX) ? mci_pkg::SX_ID : mci_pkg::SX_IDLE;
      end else if (rx_v) begin
        unique case (sx_q)
          mci_pkg::SX_IDLE: begin
            if (run_q[7:4] == 4'hc || run_q[7:4] == 4'hd || have_d1_q) begin
              msg_v_q   <= run_q[7];
              msg_st_q  <= run_q;
              msg_d1_q  <= have_d1_q ? d1_q : rx_b;
              msg_d2_q  <= rx_b;
              have_d1_q <= 1'b0;
            end else begin
              d1_q      <= rx_b;
              have_d1_q <= 1'b1;
            end
          end
          mci_pkg::SX_ID:
            sx_q <= (rx_b[6:0] == MFR_ID) ? mci_pkg::SX_CMD : mci_pkg::SX_SKIP;
          mci_pkg::SX_CMD: begin
            sx_q <= mci_pkg::SX_SKIP;
            sx_bank_mode_q <= (rx_b[6:4] == mci_pkg::SX_BANKC);
            if (ch_on && rx_b[3:0] == cur_ch[3:0]) begin
              if (rx_b[6:4] == mci_pkg::SX_REQ) dump_req_q <= 1'b1; // see R14
              if (rx_b[6:4] == mci_pkg::SX_BANKC) sx_q <= mci_pkg::SX_BANK;
              if (rx_b[6:4] == mci_pkg::SX_BULK && !ctrl_q[mci_pkg::CTRL_PROTECT])
                sx_q <= mci_pkg::SX_BANK; // see R16
            end
          end
          mci_pkg::SX_BANK: begin
            blk_bank_q <= rx_b[1:0];
            blk_ix_q   <= 7'h00;
            sx_hi_ph_q <= 1'b1;
            msg_v_q    <= sx_bank_mode_q;
            msg_st_q   <= mci_pkg::ST_SYSEX;
            msg_d1_q   <= rx_b;
            sx_q <= sx_bank_mode_q ? mci_pkg::SX_SKIP : mci_pkg::SX_DATA;
          end
          mci_pkg::SX_DATA: begin
            sx_hi_ph_q <= !sx_hi_ph_q;
            if (sx_hi_ph_q) begin
              hi_q <= rx_b;
            end else begin
              blk_ix_q <= blk_ix_q + 7'h01;
              if (blk_ix_q == 7'h7f) sx_q <= mci_pkg::SX_SKIP;
            end
          end
          mci_pkg::SX_SKIP: ;
        endcase
      end
    end
  end

  // program recall through the bank table
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      recall_valid <= 1'b0;
      recall_code  <= 9'h000;
    end else begin
      recall_valid <= 1'b0;
      if (msg_ok && msg_st_q[7:4] == 4'hc && tbl[{bank_q, msg_d1_q[6:0]}] != 9'h000) begin
        recall_valid <= 1'b1; // see R7 R23
        recall_code  <= tbl[{bank_q, msg_d1_q[6:0]}];
      end
    end
  end

  // two external controllers
  for (genvar g = 0; g < 2; g++) begin : g_ctl
    logic [6:0] num, mn, mx, val;
    logic [1:0] src;
    logic       hit;
    assign num = ctlasn_q[8*g +: 7];
    assign src = ctlasn_q[16+2*g +: 2];
    assign mn  = range_q[16*g +: 7];
    assign mx  = range_q[16*g+8 +: 7];
    always_comb begin
      unique case (src) // see R9
        2'h0: hit = msg_ok && msg_st_q[7:4] == 4'hb && msg_d1_q[6:0] == num;
        2'h1, 2'h2: hit = note_on;
        2'h3: hit = msg_ok && msg_st_q[7:4] == 4'hd;
      endcase
      val = (src == 2'h0 || src == 2'h2) ? msg_d2_q[6:0] : msg_d1_q[6:0];
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) par_q[g] <= 8'h00;
      else if (hit) par_q[g] <= scale(mn, mx, val); // see R21
    end
  end
  assign param1_val = par_q[0];
  assign param2_val = par_q[1];

  // pitch, gate and playback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pitch_semi <= 8'h00;
      pitch_fine <= 8'h00;
      harmony_interval <= 8'h00;
      playing <= 1'b0;
      gate_open <= 1'b0;
    end else begin
      gate_open <= note_on && ctrl_q[mci_pkg::CTRL_TRIGF] && eff >= mci_pkg::EFF_REVERB &&
                   eff <= mci_pkg::EFF_TRIGGERED_PAN_PROGRAM; // see R10
      if (wr_en && awaddr_q == mci_pkg::OFS_PITCH) begin
        pitch_semi <= clamp_s({wr_val[7], wr_val[7:0]}, mci_pkg::PITCH_LIM); // see R2
        pitch_fine <= clamp_s({wr_val[15], wr_val[15:8]}, mci_pkg::FINE_LIM); // see R1
      end else if (note_on && key_on) begin
        if (((eff >= mci_pkg::EFF_MONO_PITCH_PROGRAM && eff <= mci_pkg::EFF_TRIPLE_PITCH_PROGRAM) &&
             !ctrl_q[mci_pkg::CTRL_HARMONY]) || eff == mci_pkg::EFF_STEREO_PITCH_PROGRAM ||
            eff == mci_pkg::EFF_FREEZE)
          pitch_semi <= note_int; // see R3 R11
      end
      if (note_on && key_on && ctrl_q[mci_pkg::CTRL_HARMONY] &&
          ctrl_q[mci_pkg::CTRL_TRIGEXT] &&
          eff >= mci_pkg::EFF_MONO_PITCH_PROGRAM && eff <= mci_pkg::EFF_TRIPLE_PITCH_PROGRAM)
        harmony_interval <= note_int; // see R12
      if (eff != mci_pkg::EFF_FREEZE) playing <= 1'b0;
      else if (note_off) playing <= 1'b0; // see R4
      else if (note_on) playing <= 1'b1;
    end
  end

  // tempo from timing clock spacing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_cnt_q <= 24'h000000;
      tempo_cycles <= 24'h000000;
    end else if (msg_v_q && msg_st_q == mci_pkg::ST_CLOCK) begin
      clk_cnt_q <= 24'h000001;
      if (ch_on && ctrl_q[mci_pkg::CTRL_TRIGEXT] && eff >= mci_pkg::EFF_TEMPO_ECHO_SINGLE &&
          eff <= mci_pkg::EFF_TEMPO_ECHO_QUAD)
        tempo_cycles <= clk_cnt_q; // see R13
    end else if (clk_cnt_q != 24'hffffff) begin
      clk_cnt_q <= clk_cnt_q + 24'h000001;
    end
  end

  // dump of the selected bank table
  assign dump_tmp = dump_ix_q - 9'h004;
  assign dump_ent = tbl[{bank_q, dump_tmp[7:1]}];
  always_comb begin
    if (dump_ix_q == 9'h000) dump_byte = mci_pkg::ST_SYSEX;
    else if (dump_ix_q == 9'h001) dump_byte = {1'b0, MFR_ID};
    else if (dump_ix_q == 9'h002) dump_byte = {1'b0, mci_pkg::SX_BULK, cur_ch[3:0]};
    else if (dump_ix_q == 9'h003) dump_byte = {6'h00, bank_q};
    else if (dump_ix_q == mci_pkg::DUMP_LAST) dump_byte = mci_pkg::ST_EOX;
    else dump_byte = dump_tmp[0] ? {1'b0, dump_ent[6:0]} : {6'h00, dump_ent[8:7]};
  end

  // serial transmitter; dumps are only started in transmit mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dump_act_q <= 1'b0;
      dump_ix_q <= 9'h000;
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3ff;
      tx_bit_q <= 4'h0;
      tx_cnt_q <= 16'h0000;
    end else begin
      if (!dump_act_q && ctrl_q[mci_pkg::CTRL_XMIT] &&
          (dump_req_q || (wr_en && awaddr_q == mci_pkg::OFS_CTRL &&
                          wr_val[mci_pkg::CTRL_DUMPGO]))) begin
        dump_act_q <= 1'b1; // see R6 R14
        dump_ix_q <= 9'h000;
      end
      if (!tx_busy_q) begin
        if (dump_act_q) begin
          tx_sh_q <= {1'b1, dump_byte, 1'b0};
          tx_busy_q <= 1'b1;
          tx_bit_q <= 4'h0;
          tx_cnt_q <= 16'h0000;
          dump_ix_q <= dump_ix_q + 9'h001;
          if (dump_ix_q == mci_pkg::DUMP_LAST) dump_act_q <= 1'b0;
        end
      end else if (tx_cnt_q == 16'(BIT_CYC - 1)) begin
        tx_cnt_q <= 16'h0000;
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == 4'h9) tx_busy_q <= 1'b0;
      end else begin
        tx_cnt_q <= tx_cnt_q + 16'h0001;
      end
    end
  end
  assign tx_line = tx_busy_q ? tx_sh_q[0] : 1'b1;

  // output port and indicator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      midi_out <= 1'b1;
      midi_led <= 1'b0;
    end else begin
      midi_out <= ctrl_q[mci_pkg::CTRL_XMIT] ? tx_line : midi_in; // see R5 R6
      midi_led <= rx_busy; // see R19
    end
  end
endmodule

// [bench/mci_chk.sv]
// port assertions for the midi control interpreter
`timescale 1ns/100ps
module mci_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       midi_in,
  input wire logic       midi_led,
  input wire logic       recall_valid,
  input wire logic [8:0] recall_code,
  input wire logic [7:0] param1_val,
  input wire logic [7:0] param2_val,
  input wire logic       gate_open,
  input wire logic [7:0] pitch_semi,
  input wire logic [7:0] pitch_fine
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fine_range_a: assert property ($signed(pitch_fine) >= -100 && $signed(pitch_fine) <= 100)
    else $error("fine pitch out of range");
  coarse_range_a: assert property ($signed(pitch_semi) >= -24 && $signed(pitch_semi) <= 24)
    else $error("coarse pitch out of range");
  recall_pulse_a: assert property (recall_valid |=> !recall_valid)
    else $error("recall pulse too long");
  recall_code_a: assert property (recall_valid |-> recall_code <= mci_pkg::CODE_MAX)
    else $error("recall code out of range");
  recall_none_a: assert property (recall_valid |-> recall_code != 9'h000)
    else $error("recall of empty entry");
  gate_pulse_a: assert property (gate_open |=> !gate_open)
    else $error("gate pulse too long");
  param_window_a: assert property (param1_val <= 8'h64 && param2_val <= 8'h64)
    else $error("controller value above full scale");
  // a start bit must light the indicator within half a bit of the bench rate
  led_on_a: assert property (!midi_led && $fell(midi_in) |-> ##[1:8] midi_led)
    else $error("indicator not lit by incoming frame");
endmodule
bind mci_top mci_chk u_chk (.*);

// [bench/mci_midi_src.sv]
// serial midi sender standing in for the external keyboard
`timescale 1ns/100ps
module mci_midi_src #(
  parameter int unsigned BIT_CYC = 16
) (
  input wire logic aclk,
  output logic     txd
);
  initial txd = 1'b1;
  // one 8n1 frame, lsb first; the line rests at its idle high level afterwards
  task automatic snd(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd <= f[i];
      repeat (BIT_CYC) @(posedge aclk);
    end
  endtask
endmodule

// [bench/tb.sv]
// self-checking bench for the midi control interpreter
`timescale 1ns/100ps
module tb;
  localparam int unsigned BC = 16;
  logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, midi_in, midi_out;
  logic        midi_led, recall_valid, gate_open, playing, prev_in, thru = 1'b1;
  logic [1:0]  s_bresp, s_rresp, r;
  logic [3:0]  s_wstrb;
  logic [7:0]  s_awaddr, s_araddr, param1_val, param2_val, pitch_semi, pitch_fine;
  logic [7:0]  harmony_interval;
  logic [8:0]  recall_code;
  logic [23:0] tempo_cycles;
  logic [31:0] s_wdata, s_rdata, d;
  int          bad_count, n_compared, n_rc, n_g, k;
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  mci_top #(.BIT_CYC(BC)) DUT (.*);
  mci_midi_src #(.BIT_CYC(BC)) src (.aclk(aclk), .txd(midi_in));
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  always @(posedge aclk) begin
    prev_in <= midi_in;
    if (aresetn === 1'b1 && thru) ck(midi_out, prev_in);
    if (recall_valid === 1'b1) n_rc++;
    if (gate_open === 1'b1) n_g++;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bready && s_bvalid) begin
        s_bready <= 1'b0;
        r = s_bresp;
      end
    end while (s_awvalid || s_wvalid || s_bready);
  endtask
  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rready && s_rvalid) begin
        s_rready <= 1'b0;
        d = s_rdata;
        r = s_rresp;
      end
    end while (s_arvalid || s_rready);
  endtask
  // bytes leave from the top of m; the channel is carried in m: channel 0, except one program change on channel 1
  task automatic tx(input logic [39:0] m, input int n);
    for (int i = n - 1; i >= 0; i--) src.snd(m[i*8 +: 8]);
  endtask
  task automatic t_reg;
    rd(mci_pkg::OFS_STATUS);
    ck(d, 32'h0);
    rd(8'h24);
    ck(r, mci_pkg::RESP_SLVERR);
    wr(8'h22, 32'h0);
    ck(r, mci_pkg::RESP_SLVERR);
  endtask
  task automatic t_pgm;
    wr(mci_pkg::OFS_TABLE, 32'h0000_0718);
    ck(r, mci_pkg::RESP_OKAY);
    wr(mci_pkg::OFS_TABLE, 32'h0000_0800);
    k = n_rc;
    tx(40'hc003, 2);
    ck(n_rc, k + 1);
    ck(recall_code, 9'h118);
    tx(40'hc103, 2);
    ck(n_rc, k + 1);
    tx(40'hc004, 2);
    ck(n_rc, k + 1);
    tx(40'hf07d000000, 5);
    tx(40'h05f7, 2);
    tx(40'hc000, 2);
    ck(recall_code, 9'h005);
  endtask
  task automatic t_pitch;
    wr(mci_pkg::OFS_CTRL, 32'h0000_0900);
    wr(mci_pkg::OFS_PITCH, 32'h0024_7f30);
    ck(pitch_fine, 8'h64);
    ck(pitch_semi, 8'h18);
    tx(40'h903040, 3);
    ck(pitch_semi, 8'h0c);
    ck(playing, 1'b1);
    tx(40'h803000, 3);
    ck(playing, 1'b0);
  endtask
  task automatic t_misc;
    wr(mci_pkg::OFS_CTRL, 32'h0000_0110);
    k = n_g;
    tx(40'h903040, 3);
    ck(n_g, k + 1);
    tx(40'hb0017f, 3);
    ck(param1_val, 8'h64);
    wr(mci_pkg::OFS_RANGE, 32'h5a0a_6400);
    tx(40'hb0027f, 3);
    ck(param2_val, 8'h5a);
    wr(mci_pkg::OFS_CTRL, 32'h0000_0560);
    tx(40'h902a40, 3);
    ck(harmony_interval, 8'h06);
    ck(pitch_semi, 8'h0c);
    wr(mci_pkg::OFS_CTRL, 32'h0000_0a40);
    tx(40'hf8f8, 2);
    ck(tempo_cycles, 10 * BC);
    tx(40'hf07d1001f7, 5);
    rd(mci_pkg::OFS_CTRL);
    ck(d[3:2], 2'h1);
  endtask
  // transmit mode: a dump request must put frames on an otherwise idle output
  task automatic t_dump;
    thru <= 1'b0;
    wr(mci_pkg::OFS_CTRL, 32'h0000_0001);
    tx(40'hf07d20f7, 4);
    k = 0;
    repeat (4 * BC) begin
      @(posedge aclk);
      if (midi_out === 1'b0) k++;
    end
    ck(k != 0, 1'b1);
    rd(mci_pkg::OFS_STATUS);
    ck(d[11], 1'b1);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // generous bound: the whole sequence is a few thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    close_out();
  end
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = {8'h00, 8'h00, 32'h0, 4'hf};
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reg();
    t_pgm();
    t_pitch();
    t_misc();
    t_dump();
    close_out();
  end
endmodule
